// ### t16cc_pkg.sv
// package for the 16-bit capture/compare timer register block
// assumes an axi4-lite master on the same clock as the timer
package t16cc_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] CTRL_A_ADDR   = 8'h00;
  localparam logic [7:0] CTRL_B_ADDR   = 8'h04;
  localparam logic [7:0] CNT_LO_ADDR   = 8'h08;
  localparam logic [7:0] CNT_HI_ADDR   = 8'h0c;
  localparam logic [7:0] CMPA_LO_ADDR  = 8'h10;
  localparam logic [7:0] CMPA_HI_ADDR  = 8'h14;
  localparam logic [7:0] CMPB_LO_ADDR  = 8'h18;
  localparam logic [7:0] CMPB_HI_ADDR  = 8'h1c;
  localparam logic [7:0] CAP_LO_ADDR   = 8'h20;
  localparam logic [7:0] CAP_HI_ADDR   = 8'h24;
  localparam logic [7:0] MASK_ADDR     = 8'h28;
  localparam logic [7:0] FLAGS_ADDR    = 8'h2c;
  localparam logic [7:0] VECTOR_ADDR   = 8'h30;
  // ==========================================================
  // field positions
  localparam int CB_FILTER  = 7;
  localparam int CB_EDGE    = 6;
  localparam int CB_RSVD    = 5;
  localparam int CA_FOC_A   = 3;
  localparam int CA_FOC_B   = 2;
  localparam int IRQ_CAP    = 5;
  localparam int IRQ_CMPA   = 4;
  localparam int IRQ_CMPB   = 3;
  localparam int IRQ_OVF    = 2;
  localparam logic [7:0] IRQ_BITS  = 8'h3c;
  localparam logic [7:0] CB_WMASK  = 8'hdf;
  localparam logic [7:0] CA_WMASK  = 8'h03;
  // ==========================================================
  // reset values and counts
  localparam logic [7:0]  RST8     = 8'h00;
  localparam logic [15:0] RST16    = 16'h0000;
  localparam int          FILT_LEN = 4;
  localparam logic [15:0] MAX16    = 16'hffff;
  localparam logic [3:0]  WM_CTC_ICR = 4'hc;
  localparam logic [3:0]  WM_FPWM_ICR = 4'he;
  localparam logic [3:0]  WM_PC_ICR = 4'ha;
  localparam logic [3:0]  WM_PFC_ICR = 4'h8;
  localparam logic [3:0]  WM_NORMAL = 4'h0;
  localparam logic [3:0]  WM_CTC_A  = 4'h4;
  localparam logic [9:0]  DIV8  = 10'h007;
  localparam logic [9:0]  DIV64 = 10'h03f;
  localparam logic [9:0]  DIV256 = 10'h0ff;
  localparam logic [9:0]  DIV1024 = 10'h3ff;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ### t16cc_timer.sv
// 16-bit timer with two compare channels and one capture channel
// assumes axi4-lite master and pins; pins are synchronised here
// ==========================================================
// Notes on behaviour
// - filter on: output changes only after four equal capture samples.
// - filter on adds four clock cycles of capture delay.
// - edge select zero captures falling edges, one captures rising edges.
// - capture copies counter into capture register and sets capture flag.
// - capture register as top disconnects capture pin, no captures.
// - clock select 000 stops; 001-101 divide by 1,8,64,256,1024.
// - clock select 110 counts falling, 111 rising external pin edges.
// - external pin counts even when driven as an output.
// - one shared high-byte latch makes 16-bit accesses atomic.
// - counter write blocks compare matches on next timer clock.
// - each compare register compared continuously with counter.
// - capture source is pin or optionally analog comparator.
// - mask bits 5,4,3,2; irq when enable, global enable, flag set.
// - overflow flag set when counter hits top and top is MAX16 (ctc tops below it never set it).
// - capture register as top sets capture flag when counter hits top.
// - compare flag set two core clocks after the timer clock where counter equals compare.
// - forced compare strobe never sets its compare flag.
// - flags clear on vector execution or writing one to the bit.
// - waveform mode is control b bits 4:3 over control a bits 1:0.
`timescale 1ns/1ps
`default_nettype none
module t16cc_timer (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        capture_input_pin,
  input  wire logic        comparator_out,
  input  wire logic        capture_from_comparator,
  input  wire logic        external_count_pin,
  input  wire logic        global_irq_enable,
  output logic             irq_capture_q,
  output logic             irq_compare_a_q,
  output logic             irq_compare_b_q,
  output logic             irq_overflow_q,
  output logic             match_a_q,
  output logic             match_b_q
);
  // ==========================================================
  // reset release and pin synchronisers
  logic       rst_m_q, rst_n_q;
  logic [2:0] pin_m_q, pin_s_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
    end else if (clk_en) begin
      pin_m_q <= {comparator_out, capture_input_pin, external_count_pin};
      pin_s_q <= pin_m_q;
    end
  end
  // ==========================================================
  // registers
  logic [7:0]  ctrl_a_q, ctrl_b_q, mask_q, flags_q, temp_q;
  logic [15:0] cnt_q, cmpa_q, cmpb_q, cap_q;
  logic [3:0]  wave_mode;
  logic [2:0]  clock_select_field;
  logic        cap_is_top;
  assign wave_mode = {ctrl_b_q[4:3], ctrl_a_q[1:0]};
  assign clock_select_field = ctrl_b_q[2:0];
  assign cap_is_top = (wave_mode == t16cc_pkg::WM_CTC_ICR) ||
                      (wave_mode == t16cc_pkg::WM_FPWM_ICR) ||
                      (wave_mode == t16cc_pkg::WM_PC_ICR) ||
                      (wave_mode == t16cc_pkg::WM_PFC_ICR);
  // ==========================================================
  // axi4-lite handshake
  logic       aw_q, w_q, wr_go, rd_go;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awa_q         <= t16cc_pkg::RST8;
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= t16cc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awa_q > t16cc_pkg::VECTOR_ADDR || awa_q[1:0] != 2'h0)
                        ? t16cc_pkg::RESP_SLVERR : t16cc_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic       we;
  logic [7:0] wb;
  assign we = wr_go && ws_q[0];
  assign wb = wd_q[7:0];
  // ==========================================================
  // prescaler and timer clock enable
  logic [9:0] pre_q;
  logic       ext_q, tick;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_q <= 10'h000;
      ext_q <= 1'b0;
    end else if (clk_en) begin
      pre_q <= pre_q + 10'h001;
      ext_q <= pin_s_q[0];
    end
  end
  always_comb begin
    unique case (clock_select_field)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_q[2:0] == t16cc_pkg::DIV8[2:0]);
      3'h3: tick = (pre_q[5:0] == t16cc_pkg::DIV64[5:0]);
      3'h4: tick = (pre_q[7:0] == t16cc_pkg::DIV256[7:0]);
      3'h5: tick = (pre_q == t16cc_pkg::DIV1024);
      3'h6: tick = ext_q && !pin_s_q[0];
      3'h7: tick = !ext_q && pin_s_q[0];
    endcase
  end
  // ==========================================================
  // capture noise filter and edge detect
  logic       src, filt_q, filt_p_q, cap_evt;
  logic [t16cc_pkg::FILT_LEN-1:0] hist_q;
  assign src = capture_from_comparator ? pin_s_q[2] : pin_s_q[1];
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hist_q   <= {t16cc_pkg::FILT_LEN{1'b0}};
      filt_q   <= 1'b0;
      filt_p_q <= 1'b0;
    end else if (clk_en) begin
      hist_q <= {hist_q[t16cc_pkg::FILT_LEN-2:0], src};
      if (!ctrl_b_q[t16cc_pkg::CB_FILTER])
        filt_q <= src;
      else if (hist_q == {t16cc_pkg::FILT_LEN{hist_q[0]}})
        filt_q <= hist_q[0];
      filt_p_q <= filt_q;
    end
  end
  assign cap_evt = !cap_is_top &&
    (ctrl_b_q[t16cc_pkg::CB_EDGE] ? (filt_q && !filt_p_q)
                                  : (!filt_q && filt_p_q));
  // ==========================================================
  // register writes, counter and latch
  logic block_q, cnt_wr, hit_a, hit_b, top_hit, ovf;
  logic [15:0] top;
  assign cnt_wr = we && awa_q == t16cc_pkg::CNT_LO_ADDR;
  assign top = (wave_mode == t16cc_pkg::WM_CTC_A) ? cmpa_q :
               (wave_mode == t16cc_pkg::WM_CTC_ICR) ? cap_q : t16cc_pkg::MAX16;
  assign hit_a = tick && !block_q && cnt_q == cmpa_q;
  assign hit_b = tick && !block_q && cnt_q == cmpb_q;
  assign top_hit = tick && cnt_q == top;
  assign ovf = top_hit && (wave_mode == t16cc_pkg::WM_NORMAL ||
                           top == t16cc_pkg::MAX16);
  logic [7:0] rd_lo;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_a_q <= t16cc_pkg::RST8;
      ctrl_b_q <= t16cc_pkg::RST8;
      mask_q   <= t16cc_pkg::RST8;
      temp_q   <= t16cc_pkg::RST8;
      cnt_q    <= t16cc_pkg::RST16;
      cmpa_q   <= t16cc_pkg::RST16;
      cmpb_q   <= t16cc_pkg::RST16;
      cap_q    <= t16cc_pkg::RST16;
      block_q  <= 1'b0;
    end else if (clk_en) begin
      if (cnt_wr)
        block_q <= 1'b1;
      else if (tick)
        block_q <= 1'b0;
      if (cnt_wr)
        cnt_q <= {temp_q, wb};
      else if (top_hit && top != t16cc_pkg::MAX16)
        cnt_q <= t16cc_pkg::RST16;
      else if (tick)
        cnt_q <= cnt_q + 16'h0001;
      if (cap_evt)
        cap_q <= cnt_q;
      if (we) begin
        unique case (awa_q)
          t16cc_pkg::CTRL_A_ADDR:  ctrl_a_q <= wb & t16cc_pkg::CA_WMASK;
          t16cc_pkg::CTRL_B_ADDR:  ctrl_b_q <= wb & t16cc_pkg::CB_WMASK;
          t16cc_pkg::MASK_ADDR:    mask_q <= wb & t16cc_pkg::IRQ_BITS;
          t16cc_pkg::CNT_HI_ADDR,
          t16cc_pkg::CMPA_HI_ADDR,
          t16cc_pkg::CMPB_HI_ADDR,
          t16cc_pkg::CAP_HI_ADDR:  temp_q <= wb;
          t16cc_pkg::CMPA_LO_ADDR: cmpa_q <= {temp_q, wb};
          t16cc_pkg::CMPB_LO_ADDR: cmpb_q <= {temp_q, wb};
          t16cc_pkg::CAP_LO_ADDR:  if (!cap_evt) cap_q <= {temp_q, wb};
          default: ;
        endcase
      end else if (rd_go && s_axi_araddr == t16cc_pkg::CNT_LO_ADDR) begin
        temp_q <= cnt_q[15:8];
      end else if (rd_go && s_axi_araddr == t16cc_pkg::CAP_LO_ADDR) begin
        temp_q <= cap_q[15:8];
      end else if (rd_go && s_axi_araddr == t16cc_pkg::CMPA_LO_ADDR) begin
        temp_q <= cmpa_q[15:8];
      end else if (rd_go && s_axi_araddr == t16cc_pkg::CMPB_LO_ADDR) begin
        temp_q <= cmpb_q[15:8];
      end
    end
  end
  // ==========================================================
  // flags: set wins over clear
  logic [7:0] set_v, clr_v;
  logic       match_a_q2, match_b_q2;
  assign set_v = {2'h0, cap_evt || (cap_is_top && top_hit),
                  match_a_q2, match_b_q2, ovf, 2'h0};
  assign clr_v = ((we && awa_q == t16cc_pkg::FLAGS_ADDR) ? wb : 8'h00) |
                 ((we && awa_q == t16cc_pkg::VECTOR_ADDR) ? wb : 8'h00);
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q    <= t16cc_pkg::RST8;
      match_a_q2 <= 1'b0;
      match_b_q2 <= 1'b0;
    end else if (clk_en) begin
      match_a_q2 <= hit_a;
      match_b_q2 <= hit_b;
      flags_q <= (set_v | (flags_q & ~clr_v)) & t16cc_pkg::IRQ_BITS;
    end
  end
  // ==========================================================
  // outputs
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_capture_q   <= 1'b0;
      irq_compare_a_q <= 1'b0;
      irq_compare_b_q <= 1'b0;
      irq_overflow_q  <= 1'b0;
      match_a_q       <= 1'b0;
      match_b_q       <= 1'b0;
    end else if (clk_en) begin
      irq_capture_q   <= global_irq_enable && mask_q[t16cc_pkg::IRQ_CAP] &&
                         flags_q[t16cc_pkg::IRQ_CAP];
      irq_compare_a_q <= global_irq_enable && mask_q[t16cc_pkg::IRQ_CMPA] &&
                         flags_q[t16cc_pkg::IRQ_CMPA];
      irq_compare_b_q <= global_irq_enable && mask_q[t16cc_pkg::IRQ_CMPB] &&
                         flags_q[t16cc_pkg::IRQ_CMPB];
      irq_overflow_q  <= global_irq_enable && mask_q[t16cc_pkg::IRQ_OVF] &&
                         flags_q[t16cc_pkg::IRQ_OVF];
      match_a_q <= hit_a ||
                   (we && awa_q == t16cc_pkg::CTRL_A_ADDR && wb[t16cc_pkg::CA_FOC_A]);
      match_b_q <= hit_b ||
                   (we && awa_q == t16cc_pkg::CTRL_A_ADDR && wb[t16cc_pkg::CA_FOC_B]);
    end
  end
  // ==========================================================
  // read channel
  always_comb begin
    unique case (s_axi_araddr)
      t16cc_pkg::CTRL_A_ADDR:  rd_lo = ctrl_a_q;
      t16cc_pkg::CTRL_B_ADDR:  rd_lo = ctrl_b_q;
      t16cc_pkg::CNT_LO_ADDR:  rd_lo = cnt_q[7:0];
      t16cc_pkg::CMPA_LO_ADDR: rd_lo = cmpa_q[7:0];
      t16cc_pkg::CMPB_LO_ADDR: rd_lo = cmpb_q[7:0];
      t16cc_pkg::CAP_LO_ADDR:  rd_lo = cap_q[7:0];
      t16cc_pkg::CNT_HI_ADDR,
      t16cc_pkg::CMPA_HI_ADDR,
      t16cc_pkg::CMPB_HI_ADDR,
      t16cc_pkg::CAP_HI_ADDR:  rd_lo = temp_q;
      t16cc_pkg::MASK_ADDR:    rd_lo = mask_q;
      t16cc_pkg::FLAGS_ADDR:   rd_lo = flags_q;
      default:                 rd_lo = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= t16cc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_lo};
        s_axi_rresp  <= (s_axi_araddr > t16cc_pkg::VECTOR_ADDR ||
                         s_axi_araddr[1:0] != 2'h0)
                        ? t16cc_pkg::RESP_SLVERR : t16cc_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // checks
  sequence s_hit_a;
    clk_en && hit_a;
  endsequence
  a_cmpa_flag_next: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    s_hit_a ##1 clk_en |=> flags_q[t16cc_pkg::IRQ_CMPA])
    else $error("compare a flag not set after match");
  a_block_after_wr: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && cnt_wr |=> !hit_a && !hit_b)
    else $error("match seen right after counter write");
  a_cap_copies_cnt: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && cap_evt |=> cap_q == $past(cnt_q) &&
    flags_q[t16cc_pkg::IRQ_CAP])
    else $error("capture did not copy counter");
  a_no_cap_at_top: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && cap_is_top && !(we && awa_q == t16cc_pkg::CAP_LO_ADDR)
    |=> $stable(cap_q))
    else $error("capture while capture reg is top");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    ctrl_b_q[t16cc_pkg::CB_RSVD] == 1'b0 &&
    (flags_q & ~t16cc_pkg::IRQ_BITS) == 8'h00)
    else $error("reserved bit set");
  a_stop_no_tick: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && clock_select_field == 3'h0 && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  a_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && !global_irq_enable |=> !irq_overflow_q && !irq_capture_q)
    else $error("interrupt without global enable");
  a_filter_hold: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && ctrl_b_q[t16cc_pkg::CB_FILTER] &&
    hist_q != {t16cc_pkg::FILT_LEN{hist_q[0]}}
    |=> $stable(filt_q))
    else $error("filter changed without four samples");
  a_ovf_flag: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && ovf |=> flags_q[t16cc_pkg::IRQ_OVF])
    else $error("overflow flag not set");
  a_clear_flag: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    clk_en && clr_v[t16cc_pkg::IRQ_CMPB] && !match_b_q2
    |=> !flags_q[t16cc_pkg::IRQ_CMPB])
    else $error("flag not cleared by write of one");
endmodule
`default_nettype wire

// ### t16cc_cpu_model.sv
// cpu model: axi4-lite master making one register access at a time
// assumes core_clk is shared with the timer; payload inverted when released
`timescale 1ns/1ps
`default_nettype none
module t16cc_cpu_model (
  input  wire logic        core_clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // ==========================================================
  // idle values
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // ==========================================================
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  // ==========================================================
  // read: address held until taken, rready held until rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### t16cc_tb_top.sv
// testbench: register-level checks of the capture/compare timer
// assumes t16cc_cpu_model as bus master; bench drives the pins
`timescale 1ns/1ps
`default_nettype none
module t16cc_tb_top;
  // ==========================================================
  // signals
  logic        core_clk, resetn, clk_en, capture_input_pin;
  logic        comparator_out, capture_from_comparator;
  logic        external_count_pin, global_irq_enable, irq_capture_q;
  logic        irq_compare_a_q, irq_compare_b_q, irq_overflow_q;
  logic        match_a_q, match_b_q, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] v16;
  int          n_mismatch, check_count, lo, hi, c_u, c_f;
  int          runs [6] = '{64, 16, 128, 1024, 4096, 16384};
  // ==========================================================
  // design and cpu model
  t16cc_timer u_t16cc_timer (.core_clk, .resetn, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .capture_input_pin, .comparator_out, .capture_from_comparator,
    .external_count_pin, .global_irq_enable, .irq_capture_q,
    .irq_compare_a_q, .irq_compare_b_q, .irq_overflow_q, .match_a_q,
    .match_b_q);
  t16cc_cpu_model u_t16cc_cpu_model (.core_clk, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always #20 core_clk = ~core_clk;
  // ==========================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk_val(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int l, input int h,
                         input logic [15:0] g);
    check_count++;
    if ((g >= l && g <= h) !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d..%0d seen %h", n, l, h, g);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    u_t16cc_cpu_model.wr(a, d, rsp);
  endtask
  task automatic r(input logic [7:0] a);
    u_t16cc_cpu_model.rd(a, rdv, rsp);
  endtask
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    w(a + 8'h04, {24'h0, v[15:8]});
    w(a, {24'h0, v[7:0]});
  endtask
  task automatic r16(input logic [7:0] a, output logic [15:0] v);
    r(a);
    v[7:0] = rdv[7:0];
    r(a + 8'h04);
    v[15:8] = rdv[7:0];
  endtask
  task automatic chk_flags(input logic [7:0] e);
    r(t16cc_pkg::FLAGS_ADDR);
    chk_val("irq flags", {24'h0, e}, rdv);
  endtask
  task automatic ext_pulses(input int n);
    repeat (n) begin
      external_count_pin <= 1'b1;
      cyc(4);
      external_count_pin <= 1'b0;
      cyc(4);
    end
    cyc(6);
  endtask
  task automatic cap_lat(input logic lvl, output int c);
    capture_input_pin <= lvl;
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (irq_capture_q !== 1'b1 && c < 40);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    {core_clk, resetn, comparator_out, capture_from_comparator} = '0;
    {external_count_pin, n_mismatch, check_count} = '0;
    {clk_en, capture_input_pin, global_irq_enable} = 3'h7;
    cyc(20);
    resetn <= 1'b1;
    cyc(4);
    r16(t16cc_pkg::CNT_LO_ADDR, v16);
    chk_val("count reset", 32'h0, {16'h0, v16});
    r(t16cc_pkg::CTRL_B_ADDR);
    chk_val("control b reset", 32'h0, rdv);
    r(t16cc_pkg::MASK_ADDR);
    chk_val("mask reset", 32'h0, rdv);
    chk_flags(8'h00);
    w(t16cc_pkg::CTRL_B_ADDR, 32'hff);
    r(t16cc_pkg::CTRL_B_ADDR);
    chk_val("control b", 32'hdf, rdv);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h00);
    w(t16cc_pkg::MASK_ADDR, 32'hff);
    r(t16cc_pkg::MASK_ADDR);
    chk_val("irq mask", 32'h3c, rdv);
    w(t16cc_pkg::FLAGS_ADDR, 32'hff);
    chk_flags(8'h00);
    r(8'h34);
    chk_val("unmapped resp", {30'h0, t16cc_pkg::RESP_SLVERR}, {30'h0, rsp});
    w(8'h34, 32'h0);
    chk_val("unmapped wresp", {30'h0, t16cc_pkg::RESP_SLVERR}, {30'h0, rsp});
    w16(t16cc_pkg::CMPA_LO_ADDR, 16'h0110);
    w16(t16cc_pkg::CMPB_LO_ADDR, 16'h0120);
    r16(t16cc_pkg::CMPA_LO_ADDR, v16);
    chk_val("compare a", 32'h0110, {16'h0, v16});
    w16(t16cc_pkg::CNT_LO_ADDR, 16'h0100);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h01);
    cyc(60);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h00);
    chk_flags(8'h18);
    chk_val("irq compare a", 32'h1, {31'h0, irq_compare_a_q});
    chk_val("irq overflow", 32'h0, {31'h0, irq_overflow_q});
    global_irq_enable <= 1'b0;
    cyc(3);
    chk_val("irq compare b", 32'h0, {31'h0, irq_compare_b_q});
    global_irq_enable <= 1'b1;
    w(t16cc_pkg::FLAGS_ADDR, 32'h10);
    chk_flags(8'h08);
    w(t16cc_pkg::FLAGS_ADDR, 32'h00);
    chk_flags(8'h08);
    w(t16cc_pkg::VECTOR_ADDR, 32'h08);
    chk_flags(8'h00);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h01);
    w16(t16cc_pkg::CNT_LO_ADDR, 16'h0110);
    cyc(4);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h00);
    chk_flags(8'h00);
    w16(t16cc_pkg::CNT_LO_ADDR, 16'hfff0);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h01);
    cyc(30);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h00);
    chk_flags(8'h04);
    w(t16cc_pkg::FLAGS_ADDR, 32'h3c);
    for (int i = 0; i < 6; i++) begin
      w16(t16cc_pkg::CNT_LO_ADDR, 16'h0000);
      w(t16cc_pkg::CTRL_B_ADDR, 32'(i));
      cyc(runs[i]);
      w(t16cc_pkg::CTRL_B_ADDR, 32'h00);
      r16(t16cc_pkg::CNT_LO_ADDR, v16);
      lo = (i == 0) ? 0 : 15;
      hi = (i == 0) ? 0 : 24;
      chk_rng("prescaled count", lo, hi, v16);
    end
    w16(t16cc_pkg::CNT_LO_ADDR, 16'h0000);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h06);
    ext_pulses(5);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h07);
    ext_pulses(3);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h00);
    r16(t16cc_pkg::CNT_LO_ADDR, v16);
    chk_val("external count", 32'h8, {16'h0, v16});
    w16(t16cc_pkg::CNT_LO_ADDR, 16'h1234);
    cap_lat(1'b0, c_u);
    chk_flags(8'h20);
    r16(t16cc_pkg::CAP_LO_ADDR, v16);
    chk_val("capture value", 32'h1234, {16'h0, v16});
    w(t16cc_pkg::FLAGS_ADDR, 32'h20);
    capture_input_pin <= 1'b1;
    cyc(12);
    chk_flags(8'h00);
    w(t16cc_pkg::CTRL_B_ADDR, 32'hc0);
    w16(t16cc_pkg::CNT_LO_ADDR, 16'h0abc);
    capture_input_pin <= 1'b0;
    cyc(12);
    capture_input_pin <= 1'b1;
    cyc(2);
    capture_input_pin <= 1'b0;
    cyc(12);
    chk_flags(8'h00);
    cap_lat(1'b1, c_f);
    chk_val("filter delay", 32'h4, 32'(c_f - c_u));
    r16(t16cc_pkg::CAP_LO_ADDR, v16);
    chk_val("filtered capture", 32'h0abc, {16'h0, v16});
    w(t16cc_pkg::FLAGS_ADDR, 32'h20);
    capture_from_comparator <= 1'b1;
    w(t16cc_pkg::CTRL_B_ADDR, 32'h40);
    comparator_out <= 1'b1;
    cyc(12);
    chk_flags(8'h20);
    w(t16cc_pkg::FLAGS_ADDR, 32'h20);
    capture_from_comparator <= 1'b0;
    w16(t16cc_pkg::CNT_LO_ADDR, 16'h0000);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h58);
    capture_input_pin <= 1'b0;
    cyc(12);
    capture_input_pin <= 1'b1;
    cyc(12);
    chk_flags(8'h00);
    w(t16cc_pkg::CTRL_B_ADDR, 32'h00);
    w(t16cc_pkg::CTRL_A_ADDR, 32'h0c);
    chk_val("force match", 32'h3, {30'h0, match_a_q, match_b_q});
    cyc(4);
    chk_flags(8'h00);
    wrap_up();
  end
  initial begin
    cyc(60000);
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
